// ### core/tiopb_pkg.sv
// Constants shared by the triple I/O port block.
// Assumes a single system clock and an 8-line layout per port.
package tiopb_pkg;

  localparam int LINES  = 8;
  localparam int PORTS  = 3;
  localparam int ADDR_W = 3;

  // Port numbers
  localparam int PORT_A = 0;
  localparam int PORT_B = 1;
  localparam int PORT_C = 2;

  // Register indices in the data space window
  localparam logic [2:0] PORT_A_DATA_IDX      = 3'h0;
  localparam logic [2:0] PORT_B_DATA_IDX      = 3'h1;
  localparam logic [2:0] PORT_C_DATA_IDX      = 3'h2;
  localparam logic [2:0] PORT_A_DIRECTION_IDX = 3'h3;
  localparam logic [2:0] PORT_B_DIRECTION_IDX = 3'h4;
  localparam logic [2:0] PORT_C_DIRECTION_IDX = 3'h5;

  // Reset values of data and direction registers, per port
  localparam logic [7:0] DATA_RST [0:2] = '{8'h00, 8'h00, 8'h04};
  localparam logic [7:0] DIR_RST  [0:2] = '{8'h00, 8'h00, 8'h04};

  // Fixed output type: one bit per line, set means push-pull
  localparam logic [7:0] PUSH_PULL_MASK [0:2] = '{8'h0f, 8'hff, 8'h00};
  // Lines that own a pull-up resistor
  localparam logic [7:0] PULLUP_MASK    [0:2] = '{8'h0f, 8'hff, 8'h0f};

  // Port C line positions of the shared functions
  localparam int SPI_CLOCK_LINE  = 0;
  localparam int SPI_DATA_LINE   = 1;
  localparam int SPI_ENABLE_LINE = 3;
  localparam int POWER_IRQ_LINE  = 4;
  localparam int IR_IRQ_LINE     = 6;

  // Answer for an unmapped read
  localparam logic [7:0] UNMAPPED_RDATA = 8'h00;

endpackage

// ### core/tiopb_line.sv
// One port line: pin synchroniser and registered pad controls.
// Assumes the pad wire is resolved outside from pin_out and pin_oe.
`timescale 1ns/100ps
module tiopb_line #(
  parameter bit PUSH_PULL = 1'b1,
  parameter bit HAS_PULLUP = 1'b1,
  parameter bit PULLUP_RST = 1'b1
)(
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic reset,
  // Line configuration
  input  wire logic dir,
  input  wire logic line_data_bit,
  input  wire logic periph_out,
  // Pad side
  input  wire logic pin_in,
  output      logic pin_out,
  output      logic pin_oe,
  output      logic pullup_en,
  output      logic pin_level
);

  logic meta_ff;
  logic level_ff;
  logic out_ff;
  logic oe_ff;
  logic pu_ff;
  logic drive_val;
  logic nxt_out;
  logic nxt_oe;
  logic nxt_pu;

  // Two-stage synchroniser, only level_ff is read
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      meta_ff  <= 1'b0;
      level_ff <= 1'b0;
    end
    else
    begin
      meta_ff  <= pin_in;
      level_ff <= meta_ff;
    end
  end

  always_comb
  begin
    // Shared lines behave as a wired AND with the peripheral
    drive_val = line_data_bit & periph_out;
    if (PUSH_PULL)
    begin
      nxt_out = drive_val;
      nxt_oe  = dir;
    end
    else
    begin
      // Open drain: only ever pulls low
      nxt_out = 1'b0;
      nxt_oe  = dir & ~drive_val;
    end
    nxt_pu = HAS_PULLUP & ~dir & ~line_data_bit;
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      out_ff <= 1'b0;
      oe_ff  <= 1'b0;
      pu_ff  <= PULLUP_RST;
    end
    else
    begin
      out_ff <= nxt_out;
      oe_ff  <= nxt_oe;
      pu_ff  <= nxt_pu;
    end
  end

  assign pin_out   = out_ff;
  assign pin_oe    = oe_ff;
  assign pullup_en = pu_ff;
  assign pin_level = level_ff;

endmodule

// ### core/tiopb_top.sv
// Three 8-line general purpose ports with data and direction registers.
// Assumes a CPU data-space access port on clk_sys and external pads.
`timescale 1ns/100ps
module tiopb_top (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       reset,
  // CPU data space access
  input  wire logic [2:0] reg_addr,
  input  wire logic       reg_wr_en,
  input  wire logic       reg_rd_en,
  input  wire logic [7:0] reg_wdata,
  output      logic [7:0] reg_rdata,
  // Single bit set or reset
  input  wire logic       bit_op_valid,
  input  wire logic       bit_op_set,
  input  wire logic [2:0] bit_op_addr,
  input  wire logic [2:0] bit_op_index,
  // Serial peripheral and interrupt latches
  input  wire logic       spi_clock_out,
  input  wire logic       spi_data_out,
  input  wire logic       serial_enable_line,
  output      logic       spi_clock_in,
  output      logic       spi_data_in,
  output      logic       power_interrupt_input,
  output      logic       infrared_interrupt_input,
  // Port A pads
  input  wire logic [7:0] port_a_pin_in,
  output      logic [7:0] port_a_pin_out,
  output      logic [7:0] port_a_pin_oe,
  output      logic [7:0] port_a_pullup_en,
  // Port B pads
  input  wire logic [7:0] port_b_pin_in,
  output      logic [7:0] port_b_pin_out,
  output      logic [7:0] port_b_pin_oe,
  output      logic [7:0] port_b_pullup_en,
  // Port C pads
  input  wire logic [7:0] port_c_pin_in,
  output      logic [7:0] port_c_pin_out,
  output      logic [7:0] port_c_pin_oe,
  output      logic [7:0] port_c_pullup_en
);

  logic [7:0] data_ff    [0:2];
  logic [7:0] dir_ff     [0:2];
  logic [7:0] pin_in_w   [0:2];
  logic [7:0] periph_w   [0:2];
  logic [7:0] level_w    [0:2];
  logic [7:0] out_w      [0:2];
  logic [7:0] oe_w       [0:2];
  logic [7:0] pu_w       [0:2];
  logic [7:0] readback_w [0:2];
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic [7:0] bit_mask;

  assign pin_in_w[0] = port_a_pin_in;
  assign pin_in_w[1] = port_b_pin_in;
  assign pin_in_w[2] = port_c_pin_in;

  // Unshared lines see an all-ones peripheral term, so data passes through
  assign periph_w[0] = 8'hff;
  assign periph_w[1] = 8'hff;
  assign periph_w[2] = {4'hf, serial_enable_line, 1'b1,
                        spi_data_out, spi_clock_out};

  assign bit_mask = 8'h01 << bit_op_index;

  // Per-line pad cells and readback
  genvar p, i;
  generate
    for (p = 0; p < tiopb_pkg::PORTS; p++)
    begin : g_port
      for (i = 0; i < tiopb_pkg::LINES; i++)
      begin : g_line
        // Bit i of both registers drives line i
        tiopb_line #(
          .PUSH_PULL  (tiopb_pkg::PUSH_PULL_MASK[p][i]),
          .HAS_PULLUP (tiopb_pkg::PULLUP_MASK[p][i]),
          .PULLUP_RST (tiopb_pkg::PULLUP_MASK[p][i] &
                       ~tiopb_pkg::DIR_RST[p][i] &
                       ~tiopb_pkg::DATA_RST[p][i])
        ) u_line (
          .clk_sys       (clk_sys),
          .reset         (reset),
          .dir           (dir_ff[p][i]),
          .line_data_bit (data_ff[p][i]),
          .periph_out    (periph_w[p][i]),
          .pin_in        (pin_in_w[p][i]),
          .pin_out       (out_w[p][i]),
          .pin_oe        (oe_w[p][i]),
          .pullup_en     (pu_w[p][i]),
          .pin_level     (level_w[p][i])
        );
      end
      // Inputs read the pin, outputs the latch
      assign readback_w[p] = (dir_ff[p] & data_ff[p]) |
                             (~dir_ff[p] & level_w[p]);
    end
  endgenerate

  // Data registers: a plain write wins over a bit operation in one cycle
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      for (int k = 0; k < tiopb_pkg::PORTS; k++)
      begin
        data_ff[k] <= tiopb_pkg::DATA_RST[k];
      end
    end
    else
    begin
      for (int k = 0; k < tiopb_pkg::PORTS; k++)
      begin
        if (reg_wr_en &&
            reg_addr == tiopb_pkg::PORT_A_DATA_IDX + 3'(k))
        begin
          data_ff[k] <= reg_wdata;
        end
        else if (bit_op_valid &&
                 bit_op_addr == tiopb_pkg::PORT_A_DATA_IDX + 3'(k))
        begin
          // Pin levels of inputs land in the latch, moving pull-ups
          if (bit_op_set)
            data_ff[k] <= readback_w[k] | bit_mask;
          else
            data_ff[k] <= readback_w[k] & ~bit_mask;
        end
      end
    end
  end

  // Direction registers
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      for (int k = 0; k < tiopb_pkg::PORTS; k++)
      begin
        dir_ff[k] <= tiopb_pkg::DIR_RST[k];
      end
    end
    else
    begin
      for (int k = 0; k < tiopb_pkg::PORTS; k++)
      begin
        if (reg_wr_en &&
            reg_addr == tiopb_pkg::PORT_A_DIRECTION_IDX + 3'(k))
        begin
          dir_ff[k] <= reg_wdata;
        end
        else if (bit_op_valid &&
                 bit_op_addr == tiopb_pkg::PORT_A_DIRECTION_IDX + 3'(k))
        begin
          if (bit_op_set)
            dir_ff[k] <= dir_ff[k] | bit_mask;
          else
            dir_ff[k] <= dir_ff[k] & ~bit_mask;
        end
      end
    end
  end

  // Read mux; data registers show pins for input lines
  always_comb
  begin
    case (reg_addr)
      tiopb_pkg::PORT_A_DATA_IDX:      nxt_rdata = readback_w[0];
      tiopb_pkg::PORT_B_DATA_IDX:      nxt_rdata = readback_w[1];
      tiopb_pkg::PORT_C_DATA_IDX:      nxt_rdata = readback_w[2];
      tiopb_pkg::PORT_A_DIRECTION_IDX: nxt_rdata = dir_ff[0];
      tiopb_pkg::PORT_B_DIRECTION_IDX: nxt_rdata = dir_ff[1];
      tiopb_pkg::PORT_C_DIRECTION_IDX: nxt_rdata = dir_ff[2];
      default:                         nxt_rdata =
                                         tiopb_pkg::UNMAPPED_RDATA;
    endcase
  end

  // Read data holds until the next read
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      rdata_ff <= 8'h00;
    else if (reg_rd_en)
      rdata_ff <= nxt_rdata;
  end

  assign reg_rdata = rdata_ff;

  // Pad outputs come straight from the line cells' flip-flops
  assign port_a_pin_out   = out_w[0];
  assign port_a_pin_oe    = oe_w[0];
  assign port_a_pullup_en = pu_w[0];
  assign port_b_pin_out   = out_w[1];
  assign port_b_pin_oe    = oe_w[1];
  assign port_b_pullup_en = pu_w[1];
  assign port_c_pin_out   = out_w[2];
  assign port_c_pin_oe    = oe_w[2];
  assign port_c_pullup_en = pu_w[2];

  // Synchronised port C levels for the peripheral and latches
  assign spi_clock_in  = level_w[2][tiopb_pkg::SPI_CLOCK_LINE];
  assign spi_data_in   = level_w[2][tiopb_pkg::SPI_DATA_LINE];
  assign power_interrupt_input    = level_w[2][tiopb_pkg::POWER_IRQ_LINE];
  assign infrared_interrupt_input = level_w[2][tiopb_pkg::IR_IRQ_LINE];

  // Checks
  logic seen_ff;

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      seen_ff <= 1'b0;
    else
      seen_ff <= 1'b1;
  end

  a_input_no_drive: assert property (@(posedge clk_sys) disable iff (reset)
    (dir_ff[0] == 8'h00) |=> (port_a_pin_oe == 8'h00))
    else $error("Port A drives a pin set as input");

  a_pullup_select: assert property (@(posedge clk_sys) disable iff (reset)
    seen_ff |=> port_b_pullup_en ==
      $past(~dir_ff[1] & ~data_ff[1]))
    else $error("Port B pull-up does not follow data and direction");

  a_push_pull_drive: assert property (@(posedge clk_sys) disable iff (reset)
    seen_ff |=> (port_b_pin_oe == $past(dir_ff[1])) &&
      ((port_b_pin_out & port_b_pin_oe) ==
       $past(data_ff[1] & dir_ff[1])))
    else $error("Port B push-pull output mismatch");

  a_read_pins: assert property (@(posedge clk_sys) disable iff (reset)
    reg_rd_en && reg_addr == tiopb_pkg::PORT_A_DATA_IDX |=>
      reg_rdata == $past((dir_ff[0] & data_ff[0]) |
                         (~dir_ff[0] & level_w[0])))
    else $error("Port A read does not show pin levels");

  a_no_pullup_high: assert property (@(posedge clk_sys) disable iff (reset)
    port_a_pullup_en[7:4] == 4'h0 && port_c_pullup_en[7:4] == 4'h0)
    else $error("Pull-up enabled on a line without one");

  a_open_drain_low: assert property (@(posedge clk_sys) disable iff (reset)
    port_c_pin_out == 8'h00 && port_a_pin_out[7:4] == 4'h0)
    else $error("Open-drain line drives a high level");

  a_open_drain_oe: assert property (@(posedge clk_sys) disable iff (reset)
    seen_ff |=> port_a_pin_oe[7:4] ==
      $past(dir_ff[0][7:4] & ~data_ff[0][7:4]))
    else $error("Open-drain line floats or pulls low wrongly");

  a_reset_values: assert property (@(posedge clk_sys) disable iff (reset)
    !seen_ff |-> data_ff[2] == 8'h04 && dir_ff[2] == 8'h04 &&
      data_ff[0] == 8'h00 && dir_ff[1] == 8'h00 &&
      port_c_pin_oe == 8'h00 && port_a_pullup_en == 8'h0f)
    else $error("Wrong register or pad state after reset");

  a_spi_wired_and: assert property (@(posedge clk_sys) disable iff (reset)
    seen_ff |=> port_c_pin_oe[0] ==
      $past(dir_ff[2][0] & ~(data_ff[2][0] & spi_clock_out)))
    else $error("Serial clock line is not a wired AND");

  a_latch_feed: assert property (@(posedge clk_sys) disable iff (reset)
    seen_ff ##1 $past(port_c_pin_in[4]) |=>
      power_interrupt_input)
    else $error("Power latch input does not follow its pin");

  a_bit_op_rmw: assert property (@(posedge clk_sys) disable iff (reset)
    bit_op_valid && bit_op_set && !reg_wr_en &&
    bit_op_addr == tiopb_pkg::PORT_B_DATA_IDX |=>
      data_ff[1] == $past(readback_w[1] | bit_mask))
    else $error("Bit set does not write back the pin levels");

  a_write_store: assert property (@(posedge clk_sys) disable iff (reset)
    reg_wr_en && reg_addr == tiopb_pkg::PORT_B_DIRECTION_IDX |=>
      dir_ff[1] == $past(reg_wdata))
    else $error("Direction write was not stored");

  a_data_write: assert property (@(posedge clk_sys) disable iff (reset)
    reg_wr_en && reg_addr == tiopb_pkg::PORT_A_DATA_IDX |=>
      data_ff[0] == $past(reg_wdata))
    else $error("Data write was not stored");

  a_dir_bit_clear: assert property (@(posedge clk_sys) disable iff (reset)
    bit_op_valid && !bit_op_set && !reg_wr_en &&
    bit_op_addr == tiopb_pkg::PORT_B_DIRECTION_IDX |=>
      dir_ff[1] == $past(dir_ff[1] & ~bit_mask))
    else $error("Bit clear on a direction register failed");

  a_unmapped_read: assert property (@(posedge clk_sys) disable iff (reset)
    reg_rd_en && reg_addr > tiopb_pkg::PORT_C_DIRECTION_IDX |=>
      reg_rdata == tiopb_pkg::UNMAPPED_RDATA)
    else $error("Unmapped read returned data");

  a_read_hold: assert property (@(posedge clk_sys) disable iff (reset)
    !reg_rd_en |=> $stable(reg_rdata))
    else $error("Read data changed without a read");

  a_port_a_drive: assert property (@(posedge clk_sys) disable iff (reset)
    seen_ff |=> (port_a_pin_oe[3:0] == $past(dir_ff[0][3:0])) &&
      ((port_a_pin_out[3:0] & port_a_pin_oe[3:0]) ==
       $past(data_ff[0][3:0] & dir_ff[0][3:0])))
    else $error("Port A push-pull output mismatch");

  a_port_c_pullup: assert property (@(posedge clk_sys) disable iff (reset)
    seen_ff |=> port_c_pullup_en ==
      $past({4'h0, ~dir_ff[2][3:0] & ~data_ff[2][3:0]}))
    else $error("Port C pull-up does not follow data and direction");

  a_serial_lines: assert property (@(posedge clk_sys) disable iff (reset)
    seen_ff |=> port_c_pin_oe[3:0] ==
      $past(dir_ff[2][3:0] & ~(data_ff[2][3:0] & {serial_enable_line,
            1'b1, spi_data_out, spi_clock_out})))
    else $error("Serial lines are not a wired AND");

  a_line_feeds: assert property (@(posedge clk_sys) disable iff (reset)
    seen_ff |=> ##1
      {infrared_interrupt_input, power_interrupt_input, spi_data_in,
       spi_clock_in} == $past({port_c_pin_in[6], port_c_pin_in[4],
                              port_c_pin_in[1:0]}, 2))
    else $error("Synchronised port C levels do not follow the pins");

  c_output_drive: cover property (@(posedge clk_sys) disable iff (reset)
    reg_wr_en ##1 port_b_pin_oe != 8'h00);
  c_pin_read: cover property (@(posedge clk_sys) disable iff (reset)
    reg_rd_en && reg_addr == tiopb_pkg::PORT_C_DATA_IDX);
  c_bit_clear: cover property (@(posedge clk_sys) disable iff (reset)
    bit_op_valid && !bit_op_set);
  c_spi_low: cover property (@(posedge clk_sys) disable iff (reset)
    port_c_pin_oe[1]);

endmodule

// ### testbench/tiopb_pins_model.sv
// Board model: pads, pull-ups and external drivers on all 24 lines.
// Assumes registered pad controls from the port block on clk_sys.
`timescale 1ns/100ps
module tiopb_pins_model (
  // Clock
  input  wire logic            clk_sys,
  // Device pad controls
  input  wire logic [2:0][7:0] pin_out,
  input  wire logic [2:0][7:0] pin_oe,
  input  wire logic [2:0][7:0] pullup_en,
  // External drivers
  input  wire logic [2:0][7:0] ext_en,
  input  wire logic [2:0][7:0] ext_val,
  // Resolved pad levels
  output      logic [2:0][7:0] pin_in
);
  // Floating lines change every cycle so no stale level passes
  logic float_ff = 1'b0;

  always_ff @(posedge clk_sys)
    float_ff <= ~float_ff;

  always_comb
  begin
    for (int p = 0; p < 3; p++)
      for (int b = 0; b < 8; b++)
        if (pin_oe[p][b])
          pin_in[p][b] = pin_out[p][b];
        else if (ext_en[p][b])
          pin_in[p][b] = ext_val[p][b];
        else if (pullup_en[p][b])
          pin_in[p][b] = 1'b1;
        else
          pin_in[p][b] = float_ff;
  end
endmodule

// ### testbench/tiopb_top_tb.sv
// Bench for the port block: reset and unmapped cases, then table,
// serial, latch input and bit operation cases.
// Assumes tiopb_pins_model stands for the board at every pad.
`timescale 1ns/100ps
module tiopb_top_tb;
  typedef struct packed
  {
    logic [1:0] port;
    logic [7:0] dir;
    logic [7:0] data;
    logic [7:0] ext;
    logic [7:0] oe;
    logic [7:0] pu;
    logic [7:0] rd;
  } tiopb_row_t;

  localparam tiopb_row_t ROWS [0:7] = '{
    '{2'h0, 8'hf0, 8'h5a, 8'h3c, 8'ha0, 8'h05, 8'h5c},
    '{2'h0, 8'h0f, 8'ha5, 8'hc3, 8'h0f, 8'h00, 8'hc5},
    '{2'h0, 8'hff, 8'h0f, 8'h00, 8'hff, 8'h00, 8'h0f},
    '{2'h0, 8'h00, 8'h00, 8'hff, 8'h00, 8'h0f, 8'hff},
    '{2'h1, 8'h55, 8'h33, 8'h0f, 8'h55, 8'h88, 8'h1b},
    '{2'h1, 8'haa, 8'hff, 8'h00, 8'haa, 8'h00, 8'haa},
    '{2'h2, 8'h0f, 8'h0a, 8'hf0, 8'h05, 8'h00, 8'hfa},
    '{2'h2, 8'hf0, 8'h50, 8'h05, 8'ha0, 8'h0f, 8'h55}};

  logic            clk_sys = 1'b0;
  logic            reset = 1'b1;
  logic [2:0]      reg_addr = 3'h0;
  logic            reg_wr_en = 1'b0;
  logic            reg_rd_en = 1'b0;
  logic [7:0]      reg_wdata = 8'h00;
  logic [7:0]      reg_rdata;
  logic            bit_op_valid = 1'b0;
  logic            bit_op_set = 1'b0;
  logic [2:0]      bit_op_addr = 3'h0;
  logic [2:0]      bit_op_index = 3'h0;
  logic [2:0]      periph = 3'h7;
  logic            spi_clock_in;
  logic            spi_data_in;
  logic            pwr_irq;
  logic            ir_irq;
  logic [2:0][7:0] ext_en = '1;
  logic [2:0][7:0] ext_val = '0;
  wire  [2:0][7:0] pin_out;
  wire  [2:0][7:0] pin_oe;
  wire  [2:0][7:0] pullup_en;
  wire  [2:0][7:0] pins;
  int              mismatches = 0;
  int              compares = 0;

  always #4 clk_sys = ~clk_sys;

  tiopb_top dut_u (
    .clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .bit_op_valid(bit_op_valid), .bit_op_set(bit_op_set),
    .bit_op_addr(bit_op_addr), .bit_op_index(bit_op_index),
    .spi_clock_out(periph[0]), .spi_data_out(periph[1]),
    .serial_enable_line(periph[2]), .spi_clock_in(spi_clock_in),
    .spi_data_in(spi_data_in), .power_interrupt_input(pwr_irq),
    .infrared_interrupt_input(ir_irq),
    .port_a_pin_in(pins[0]), .port_a_pin_out(pin_out[0]),
    .port_a_pin_oe(pin_oe[0]), .port_a_pullup_en(pullup_en[0]),
    .port_b_pin_in(pins[1]), .port_b_pin_out(pin_out[1]),
    .port_b_pin_oe(pin_oe[1]), .port_b_pullup_en(pullup_en[1]),
    .port_c_pin_in(pins[2]), .port_c_pin_out(pin_out[2]),
    .port_c_pin_oe(pin_oe[2]), .port_c_pullup_en(pullup_en[2]));

  tiopb_pins_model board_u (
    .clk_sys(clk_sys), .pin_out(pin_out), .pin_oe(pin_oe),
    .pullup_en(pullup_en), .ext_en(ext_en), .ext_val(ext_val),
    .pin_in(pins));

  task automatic check(input string name, input logic [7:0] exp,
                       input logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
      mismatches++;
    end
  endtask

  // One idle cycle after each register strobe, two after a bit op, keeps drivers single per step
  task automatic reg_wr(input logic [2:0] addr, input logic [7:0] wd);
    reg_addr = addr;
    reg_wdata = wd;
    reg_wr_en = 1'b1;
    @(negedge clk_sys);
    reg_wr_en = 1'b0;
    @(negedge clk_sys);
  endtask

  task automatic reg_rd(input logic [2:0] addr, input logic [7:0] exp);
    reg_addr = addr;
    reg_rd_en = 1'b1;
    @(negedge clk_sys);
    reg_rd_en = 1'b0;
    check("reg_rdata", exp, reg_rdata);
    @(negedge clk_sys);
  endtask

  task automatic bit_op(input logic [2:0] addr, input logic [2:0] idx,
                        input logic set);
    bit_op_addr = addr;
    bit_op_index = idx;
    bit_op_set = set;
    bit_op_valid = 1'b1;
    @(negedge clk_sys);
    bit_op_valid = 1'b0;
    repeat (2) @(negedge clk_sys);
  endtask

  task automatic results();
    $display("Compares %0d, mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    #(8 * 5000);
    mismatches++;
    results();
  end

  initial
  begin
    int         p;
    logic [7:0] ex;
    repeat (4) @(negedge clk_sys);
    for (int k = 0; k < 3; k++)
    begin
      ex = tiopb_pkg::PULLUP_MASK[k] & ~tiopb_pkg::DIR_RST[k];
      check("pin_oe", 8'h00, pin_oe[k]);
      check("pullup_en", ex, pullup_en[k]);
    end
    reset = 1'b0;
    for (int k = 0; k < 3; k++)
    begin
      reg_rd(3'(k), tiopb_pkg::DATA_RST[k]);
      reg_rd(3'(k + 3), tiopb_pkg::DIR_RST[k]);
    end
    reg_wr(3'h6, 8'hff);
    reg_rd(3'h6, 8'h00);
    reg_rd(3'h7, 8'h00);
    foreach (ROWS[i])
    begin
      p = ROWS[i].port;
      ext_en[p] = ~ROWS[i].dir;
      ext_val[p] = ROWS[i].ext;
      reg_wr(3'(p + 3), ROWS[i].dir);
      reg_wr(3'(p), ROWS[i].data);
      repeat (3) @(negedge clk_sys);
      check("pin_oe", ROWS[i].oe, pin_oe[p]);
      check("pullup_en", ROWS[i].pu, pullup_en[p]);
      ex = ROWS[i].data & ROWS[i].oe & tiopb_pkg::PUSH_PULL_MASK[p];
      check("pin_out", ex, pin_out[p] & ROWS[i].oe);
      reg_rd(3'(p), ROWS[i].rd);
      reg_rd(3'(p + 3), ROWS[i].dir);
    end
    // Board pull-ups on the serial lines
    ext_en[2] = 8'h0b;
    ext_val[2] = 8'hff;
    reg_wr(3'h5, 8'h0b);
    reg_wr(3'h2, 8'h0b);
    for (int v = 0; v < 8; v++)
    begin
      periph = 3'(v);
      repeat (3) @(negedge clk_sys);
      ex = {4'h0, ~periph[2], 1'b0, ~periph[1:0]};
      check("pin_oe c", ex, pin_oe[2]);
      ex = {6'h00, spi_data_in, spi_clock_in};
      check("serial in", {6'h00, periph[1:0]}, ex);
    end
    periph = 3'h7;
    reg_wr(3'h2, 8'h09);
    repeat (2) @(negedge clk_sys);
    check("pin_oe c", 8'h02, pin_oe[2]);
    ext_en[2] = 8'hff;
    reg_wr(3'h5, 8'h00);
    for (int v = 0; v < 4; v++)
    begin
      ext_val[2] = {1'b0, v[1], 1'b0, v[0], 4'h0};
      repeat (3) @(negedge clk_sys);
      check("latch in", 8'(v), {6'h00, ir_irq, pwr_irq});
    end
    check("pullup_en c", 8'h06, pullup_en[2]);
    ext_en[1] = 8'hf0;
    ext_val[1] = 8'h00;
    reg_wr(3'h4, 8'h0f);
    reg_wr(3'h1, 8'hf3);
    repeat (3) @(negedge clk_sys);
    check("pullup_en b", 8'h00, pullup_en[1]);
    bit_op(3'h1, 3'h1, 1'b1);
    check("pullup_en b", 8'hf0, pullup_en[1]);
    ext_en[1] = 8'h00;
    reg_wr(3'h4, 8'hff);
    reg_rd(3'h1, 8'h03);
    bit_op(3'h4, 3'h0, 1'b0);
    reg_rd(3'h4, 8'hfe);
    // Write and bit op on one register in one cycle
    reg_addr = 3'h4;
    reg_wdata = 8'h0f;
    reg_wr_en = 1'b1;
    bit_op_addr = 3'h4;
    bit_op_index = 3'h7;
    bit_op_set = 1'b1;
    bit_op_valid = 1'b1;
    @(negedge clk_sys);
    reg_wr_en = 1'b0;
    bit_op_valid = 1'b0;
    @(negedge clk_sys);
    reg_rd(3'h4, 8'h0f);
    // Reset in mid-run brings every register and pad back
    reset = 1'b1;
    repeat (2) @(negedge clk_sys);
    for (int k = 0; k < 3; k++)
    begin
      ex = tiopb_pkg::PULLUP_MASK[k] & ~tiopb_pkg::DIR_RST[k];
      check("pin_oe", 8'h00, pin_oe[k]);
      check("pullup_en", ex, pullup_en[k]);
    end
    check("reg_rdata", 8'h00, reg_rdata);
    reset = 1'b0;
    for (int k = 0; k < 3; k++)
      reg_rd(3'(k + 3), tiopb_pkg::DIR_RST[k]);
    // Line 2 shows its latch, the other lines the driven 50h
    reg_rd(3'h2, 8'h54);
    results();
  end
endmodule
